/* File: src/pwdr_consts.vh */
// pwdr_consts.vh: constants of the pulse-width dimming receiver
// assumes a 100 MHz clock; included by the receiver only
`ifndef PWDR_CONSTS_VH
`define PWDR_CONSTS_VH

`define PWDR_CLK_MHZ       100
`define PWDR_ONE_MIN_US    15
`define PWDR_ONE_MAX_US    45
`define PWDR_ZERO_MIN_US   90
`define PWDR_ZERO_MAX_US   120
`define PWDR_LOAD_MIN_US   215
`define PWDR_HIGH_MIN_US   3
`define PWDR_CODE_W        5
`define PWDR_CODE_RST      5'h00
`define PWDR_CNT_W         16
`define PWDR_OVP_HYST_PCT  7
`define PWDR_STEP_UV       18'h01630
`define PWDR_OFFSET_UV     18'h02648
`define PWDR_CNT_SAT       16'hffff
`define PWDR_CNT_ONE       16'h0001
`define PWDR_CNT_CLR       16'h0000
`define PWDR_SYNC_RST      5'h05

`endif

/* File: src/pwdr_receiver.v */
// pwdr_receiver.v: single-wire pulse-width dimming receiver, brightness
// register, enable power-down and overvoltage gating of the boost switch
// assumes a free-running clock, async active-low power-on reset, and
// comparator levels for undervoltage and overvoltage from analog blocks
`include "pwdr_consts.vh"
`default_nettype none

module pwdr_receiver #(
    parameter integer CLK_MHZ = `PWDR_CLK_MHZ
) (
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_enable,
    input  wire        i_undervoltage_lockout,
    input  wire        i_dimming_serial_in,
    input  wire        i_ovp_trip,
    input  wire        i_ovp_below_hyst,
    input  wire        i_pwm_gate,
    output reg  [4:0]  o_brightness,
    output reg  [17:0] o_fb_ref_uv,
    output reg         o_boost_switch_node_on,
    output reg         o_powered_down
);

////////////////////////////////////////////////////////////////////////////
// timing counts in clock cycles

localparam integer ONE_MIN_I  = `PWDR_ONE_MIN_US * CLK_MHZ;
localparam integer ONE_MAX_I  = `PWDR_ONE_MAX_US * CLK_MHZ;
localparam integer ZERO_MIN_I = `PWDR_ZERO_MIN_US * CLK_MHZ;
localparam integer ZERO_MAX_I = `PWDR_ZERO_MAX_US * CLK_MHZ;
localparam integer LOAD_MIN_I = `PWDR_LOAD_MIN_US * CLK_MHZ;
localparam integer HIGH_MIN_I = `PWDR_HIGH_MIN_US * CLK_MHZ;

localparam [15:0] ONE_MIN  = ONE_MIN_I[15:0];
localparam [15:0] ONE_MAX  = ONE_MAX_I[15:0];
localparam [15:0] ZERO_MIN = ZERO_MIN_I[15:0];
localparam [15:0] ZERO_MAX = ZERO_MAX_I[15:0];
localparam [15:0] LOAD_MIN = LOAD_MIN_I[15:0];
localparam [15:0] HIGH_MIN = HIGH_MIN_I[15:0];
localparam [15:0] CNT_MAX  = `PWDR_CNT_SAT;
localparam [17:0] STEP_UV  = `PWDR_STEP_UV;
localparam [17:0] OFF_UV   = `PWDR_OFFSET_UV;

////////////////////////////////////////////////////////////////////////////
// input synchronisers, two flops per asynchronous pin

localparam integer N_SYNC   = 5;
localparam integer SYNC_LN  = 0;
localparam integer SYNC_EN  = 1;
localparam integer SYNC_UV  = 2;
localparam integer SYNC_OVT = 3;
localparam integer SYNC_OVH = 4;
localparam [4:0]   SYNC_RST = `PWDR_SYNC_RST;

wire [N_SYNC-1:0] async_in;
wire [N_SYNC-1:0] sync_out;

assign async_in[SYNC_LN]  = i_dimming_serial_in;
assign async_in[SYNC_EN]  = i_enable;
assign async_in[SYNC_UV]  = i_undervoltage_lockout;
assign async_in[SYNC_OVT] = i_ovp_trip;
assign async_in[SYNC_OVH] = i_ovp_below_hyst;

genvar g;
generate
    for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
        reg [1:0] ff_q;
        always @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                ff_q <= {2{SYNC_RST[g]}};
            end else begin
                ff_q <= {ff_q[0], async_in[g]};
            end
        end
        assign sync_out[g] = ff_q[1];
    end
endgenerate

wire line_hi = sync_out[SYNC_LN];
wire en_s    = sync_out[SYNC_EN];
wire uv_s    = sync_out[SYNC_UV];
wire ovt_s   = sync_out[SYNC_OVT];
wire ovh_s   = sync_out[SYNC_OVH];

wire active  = en_s & ~uv_s;

////////////////////////////////////////////////////////////////////////////
// pulse width measurement and decode

reg        line_q;
reg [15:0] low_cnt_q;
reg [15:0] low_cnt_d;
reg [15:0] high_cnt_q;
reg [15:0] high_cnt_d;
reg        armed_q;
reg        armed_d;
reg [4:0]  shift_q;
reg [4:0]  shift_d;
reg [4:0]  bright_d;

wire fall = line_q & ~line_hi;
wire rise = ~line_q & line_hi;
wire is_one  = (low_cnt_q >= ONE_MIN)
               && (low_cnt_q <= ONE_MAX);
wire is_zero = (low_cnt_q >= ZERO_MIN)
               && (low_cnt_q <= ZERO_MAX);
wire is_load = (low_cnt_q > LOAD_MIN);

always @* begin
    low_cnt_d  = low_cnt_q;
    high_cnt_d = high_cnt_q;
    armed_d    = armed_q;
    shift_d    = shift_q;
    bright_d   = o_brightness;
    if (fall) begin
        low_cnt_d = `PWDR_CNT_ONE;
    end else if (!line_hi && low_cnt_q != CNT_MAX) begin
        low_cnt_d = low_cnt_q + `PWDR_CNT_ONE;
    end
    if (!line_hi) begin
        high_cnt_d = `PWDR_CNT_CLR;
    end else if (high_cnt_q != CNT_MAX) begin
        high_cnt_d = high_cnt_q + `PWDR_CNT_ONE;
    end
    if (fall) begin
        armed_d = (high_cnt_q >= HIGH_MIN);
    end
    if (rise && armed_q) begin
        if (is_one) begin
            shift_d = {shift_q[3:0], 1'b1};
        end else if (is_zero) begin
            shift_d = {shift_q[3:0], 1'b0};
        end else if (is_load) begin
            bright_d = shift_q;
        end
        // other widths fall through untouched
    end
end

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        line_q       <= 1'b1;
        low_cnt_q    <= `PWDR_CNT_CLR;
        high_cnt_q   <= `PWDR_CNT_CLR;
        armed_q      <= 1'b0;
        shift_q      <= `PWDR_CODE_RST;
        o_brightness <= `PWDR_CODE_RST;
    end else if (!active) begin
        line_q       <= 1'b1;
        low_cnt_q    <= `PWDR_CNT_CLR;
        high_cnt_q   <= `PWDR_CNT_CLR;
        armed_q      <= 1'b0;
        shift_q      <= `PWDR_CODE_RST;
        o_brightness <= `PWDR_CODE_RST;
    end else begin
        line_q       <= line_hi;
        low_cnt_q    <= low_cnt_d;
        high_cnt_q   <= high_cnt_d;
        armed_q      <= armed_d;
        shift_q      <= shift_d;
        o_brightness <= bright_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// next values of reference, overvoltage block and switch

reg        ovp_block_q;
reg        ovp_block_d;
reg [17:0] fb_ref_d;
reg        sw_on_d;

always @* begin
    ovp_block_d = ovp_block_q;
    if (ovt_s) begin
        ovp_block_d = 1'b1;
    end else if (ovh_s) begin
        ovp_block_d = 1'b0;
    end
    fb_ref_d = OFF_UV + STEP_UV * {13'h0000, o_brightness};
    sw_on_d  = active & ~ovp_block_q & i_pwm_gate;
end

////////////////////////////////////////////////////////////////////////////
// output registers

always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        ovp_block_q            <= 1'b0;
        o_fb_ref_uv            <= OFF_UV;
        o_boost_switch_node_on <= 1'b0;
        o_powered_down         <= 1'b1;
    end else begin
        ovp_block_q            <= ovp_block_d;
        o_fb_ref_uv            <= fb_ref_d;
        o_powered_down         <= ~active;
        o_boost_switch_node_on <= sw_on_d;
    end
end

endmodule // pwdr_receiver
`default_nettype wire

/* File: verif/pwdr_receiver_sva.sv */
// port checker for the dimming receiver
// assumes one clock, async active-low reset
`default_nettype none
module pwdr_sva (input wire logic i_clk, i_nrst, i_enable, i_ovp_trip,
    i_pwm_gate, i_dimming_serial_in, o_powered_down, o_boost_switch_node_on,
    input wire logic [4:0] o_brightness, input wire logic [17:0] o_fb_ref_uv);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_hi; i_dimming_serial_in [*8]; endsequence
    property p_ref; 1 |=> o_fb_ref_uv == 18'h02648 + 18'h01630 *
        $past(o_brightness); endproperty
    a_ref: assert property (p_ref) else $error("ref");
    property p_pd; o_powered_down |-> !o_boost_switch_node_on; endproperty
    a_pd: assert property (p_pd) else $error("pd");
    property p_clr; o_powered_down [*2] |-> o_brightness == 5'h00; endproperty
    a_clr: assert property (p_clr) else $error("clr");
    property p_en; !i_enable [*3] |=> o_powered_down; endproperty
    a_en: assert property (p_en) else $error("en");
    property p_ovp; i_ovp_trip [*4] |=> !o_boost_switch_node_on; endproperty
    a_ovp: assert property (p_ovp) else $error("ovp");
    property p_gate; !i_pwm_gate [*3] |-> !o_boost_switch_node_on; endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_keep; s_hi |-> $stable(o_brightness) || o_brightness == 5'h00;
    endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_load; $changed(o_brightness) && o_brightness != 5'h00 |->
        $past(i_dimming_serial_in); endproperty
    a_load: assert property (p_load) else $error("load");
endmodule // pwdr_sva
bind pwdr_receiver pwdr_sva chk_u (.*);
`default_nettype wire

/* File: verif/pwdr_host.sv */
// open-drain host model on the dimming line
// assumes the bench clock; released line reads high
`default_nettype none
module pwdr_host #(parameter int CM = 10) (input wire logic i_clk,
    output var logic o_line);
    initial o_line = 1'b1;
    task automatic pulse(input int us);
        repeat (5 * CM) @(negedge i_clk);
        o_line = 1'b0;
        repeat (us * CM) @(negedge i_clk);
        o_line = 1'b1;
    endtask
    task automatic send(input logic [4:0] code, input int junk);
        for (int i = 4; i >= 0; i--) pulse(code[i] ? 30 : 105);
        if (junk != 0) pulse(junk);
        pulse(250);
    endtask
endmodule // pwdr_host
`default_nettype wire

/* File: verif/pwdr_receiver_bench.sv */
// self-checking bench for the dimming receiver
// assumes pwdr_host on the line and the bound checker
`default_nettype none
module pwdr_receiver_bench;
    timeunit 1ns; timeprecision 1ns;
    logic i_clk = 0, i_nrst = 0, en = 1, uv = 0, trip = 0, gate = 0;
    logic [4:0] code, last = 0, prev = 0, exp_q[$];
    wire logic line, sw, pd;
    wire logic [4:0] bri;
    wire logic [17:0] fb;
    int miscompares = 0, cmp_count = 0, cyc = 0, seed = 32'hd370;
    always #5 i_clk = ~i_clk;
    pwdr_host #(.CM(10)) host_u (.i_clk(i_clk), .o_line(line));
    pwdr_receiver #(.CLK_MHZ(10)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_enable(en), .i_undervoltage_lockout(uv), .i_ovp_trip(trip),
        .i_dimming_serial_in(line), .i_ovp_below_hyst(!trip),
        .i_pwm_gate(gate), .o_brightness(bri), .o_fb_ref_uv(fb),
        .o_boost_switch_node_on(sw), .o_powered_down(pd));
    task check(input string nm, input logic [31:0] got,
        input logic [31:0] ex);
        cmp_count++;
        if (got !== ex) begin
            miscompares++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task results;
        $display("checks %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(negedge i_clk) begin
        cyc++;
        gate <= 1'($random(seed));
        if (cyc % 16 == 0) trip <= 1'($random(seed));
        if (cyc > 80000) begin miscompares++; results(); end
        if (bri !== prev) begin
            prev = bri;
            check("bri", bri, exp_q.pop_front());
        end else begin
            check("ref", fb, 32'h2648 + 32'h1630 * bri);
        end
    end
    task off(input logic u);
        en = u;
        uv = u;
        if (last != 5'h00) exp_q.push_back(5'h00);
        last = 5'h00;
        repeat (20) @(negedge i_clk);
        check("pd", {4'h0, pd & !sw}, 5'h01);
        en = 1;
        uv = 0;
        repeat (20) @(negedge i_clk);
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_nrst = 1;
        check("rst", bri, 5'h00);
        for (int k = 0; k < 5; k++) begin
            if (k == 3) off(1'b0);
            code = k == 0 ? 5'h1f : k == 2 ? 5'h14 : 5'($random(seed));
            if (code == last) code ^= 5'h01;
            last = code;
            exp_q.push_back(code);
            host_u.send(code, k == 1 ? 60 : 0);
            repeat (10) @(negedge i_clk);
        end
        off(1'b1);
        check("left", exp_q.size(), 0);
        results();
    end
endmodule // pwdr_receiver_bench
`default_nettype wire
